// [rbm_params.svh]
// Constants for the rotate and bit-manipulation execution unit.
// Assumes inclusion by rbm_exec.sv only, not by rbm_pkg.sv.
`ifndef RBM_PARAMS_SVH
`define RBM_PARAMS_SVH
`define RBM_CY_BIT 0
`define RBM_AC_BIT 4
`define RBM_Z_BIT 6
`define RBM_BYTE_MSB 7
`define RBM_WORD_MSB 15
`define RBM_CLK_1 3'h1
`define RBM_CLK_2 3'h2
`define RBM_CLK_3 3'h3
`define RBM_CLK_4 3'h4
`define RBM_CLK_5 3'h5
`define RBM_LEN_2 3'h2
`define RBM_LEN_3 3'h3
`define RBM_LEN_4 3'h4
`define RBM_LEN_5 3'h5
`define RBM_RAM_FETCH_ADD 4'h3
`define RBM_PSW_RESET 8'h00
`endif

// [rbm_pkg.sv]
// Types for the rotate and bit-manipulation execution unit.
// Assumes a decoder that presents one decoded operation at a time.
package rbm_pkg;
  typedef enum logic [4:0] {
    RBM_OP_ROR, RBM_OP_ROL, RBM_OP_ROTATE_RIGHT_THROUGH_CARRY, RBM_OP_ROTATE_LEFT_THROUGH_CARRY, RBM_OP_ROTATE_LEFT_WORD_THROUGH_CARRY,
    RBM_OP_MOV_TO_CY, RBM_OP_MOV_FROM_CY, RBM_OP_AND, RBM_OP_OR, RBM_OP_XOR,
    RBM_OP_SET, RBM_OP_CLR, RBM_OP_SET_CY, RBM_OP_CLR_CY, RBM_OP_NOT_CY
  } rbm_op_t;
  typedef enum logic [2:0] {
    RBM_AM_SADDR, RBM_AM_SFR, RBM_AM_ACC, RBM_AM_PSW, RBM_AM_HL,
    RBM_AM_ABS, RBM_AM_NONE
  } rbm_am_t;
  typedef struct packed {
    rbm_op_t op;
    rbm_am_t am;
    logic bank_q;
    logic word_sel;
    logic [2:0] bit_idx;
    logic code_area;
    logic ram_fetch;
  } rbm_cmd_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } rbm_mem_t;
endpackage : rbm_pkg

// [rbm_exec.sv]
// Rotate and single-bit operation datapath with cycle accounting.
// Assumes decoder holds I_CMD only during the I_START cycle and memory
// answers a read with I_MEM_RDATA in the same cycle as O_MEM.rd.
`timescale 1ns/100ps
`default_nettype none
`include "rbm_params.svh"
module rbm_exec
  import rbm_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic i_cpu_clk_en,
  input wire logic i_start,
  input wire rbm_pkg::rbm_cmd_t i_cmd,
  input wire logic [7:0] i_mem_rdata,
  output logic o_busy,
  output logic o_done,
  output logic [2:0] o_len,
  output logic [3:0] o_clocks,
  output rbm_pkg::rbm_mem_t o_mem,
  output logic [7:0] o_acc,
  output logic [15:0] o_word_ax,
  output logic [15:0] o_word_bc,
  output logic [7:0] o_psw
);
  import rbm_pkg::*;

  typedef enum logic [1:0] {RBM_IDLE, RBM_READ, RBM_WAIT} rbm_st_t;

  rbm_st_t st_q, st_d;
  rbm_cmd_t cmd_q, cmd_d;
  logic [3:0] cnt_q, cnt_d;
  logic [3:0] clk_q, clk_d;
  logic [2:0] len_q, len_d;
  logic busy_q, busy_d, done_q, done_d;
  logic [7:0] a_q, a_d, psw_q, psw_d;
  logic [15:0] ax_q, ax_d, bc_q, bc_d;
  rbm_mem_t mem_q, mem_d;
  logic [3:0] base;
  logic [2:0] blen;
  logic src;
  logic [15:0] w;

  // Base clocks and byte length per form
  always_comb
  begin
    base = {1'b0, `RBM_CLK_1};
    blen = `RBM_LEN_2;
    case (i_cmd.op)
      RBM_OP_MOV_FROM_CY, RBM_OP_SET, RBM_OP_CLR:
      begin
        base = {1'b0, `RBM_CLK_2};
        blen = `RBM_LEN_3;
        if (i_cmd.am == RBM_AM_ACC) base = {1'b0, `RBM_CLK_1};
        if (i_cmd.am == RBM_AM_ACC || (i_cmd.am == RBM_AM_HL && !i_cmd.bank_q))
          blen = `RBM_LEN_2;
        if (i_cmd.am == RBM_AM_ABS) blen = i_cmd.bank_q ? `RBM_LEN_5 : `RBM_LEN_4;
        if (i_cmd.bank_q) base = {1'b0, `RBM_CLK_3};
        if (i_cmd.am == RBM_AM_PSW) base = {1'b0, `RBM_CLK_4};
      end
      RBM_OP_MOV_TO_CY, RBM_OP_AND, RBM_OP_OR, RBM_OP_XOR:
      begin
        blen = (i_cmd.am == RBM_AM_ACC || (i_cmd.am == RBM_AM_HL && !i_cmd.bank_q)) ?
               `RBM_LEN_2 : `RBM_LEN_3;
        if (i_cmd.bank_q) base = {1'b0, `RBM_CLK_2};
        if (i_cmd.am == RBM_AM_HL && i_cmd.code_area)
          base = i_cmd.bank_q ? {1'b0, `RBM_CLK_5} : {1'b0, `RBM_CLK_4};
      end
      default:
      begin
        base = {1'b0, `RBM_CLK_1};
        blen = `RBM_LEN_2;
      end
    endcase
  end

  // Source bit selection from the held command
  always_comb
  begin
    case (cmd_q.am)
      RBM_AM_ACC: src = a_q[cmd_q.bit_idx];
      RBM_AM_PSW: src = psw_q[cmd_q.bit_idx];
      default: src = i_mem_rdata[cmd_q.bit_idx];
    endcase
  end

  always_comb
  begin
    st_d = st_q;
    cmd_d = cmd_q;
    cnt_d = cnt_q;
    clk_d = clk_q;
    len_d = len_q;
    busy_d = busy_q;
    done_d = 1'b0;
    a_d = a_q;
    ax_d = ax_q;
    bc_d = bc_q;
    psw_d = psw_q;
    mem_d = '0;
    w = cmd_q.word_sel ? bc_q : ax_q;
    case (st_q)
      RBM_IDLE:
      begin
        if (i_start)
        begin
          cmd_d = i_cmd;
          len_d = blen;
          // Fetch from RAM is charged the worst case so timing never runs short
          clk_d = i_cmd.ram_fetch ? 4'((base << 1) + `RBM_RAM_FETCH_ADD) : base;
          cnt_d = 4'h1;
          busy_d = 1'b1;
          st_d = RBM_WAIT;
          if (i_cmd.am != RBM_AM_ACC && i_cmd.am != RBM_AM_PSW &&
              i_cmd.am != RBM_AM_NONE && i_cmd.op >= RBM_OP_MOV_TO_CY &&
              i_cmd.op <= RBM_OP_CLR)
          begin
            mem_d.rd = 1'b1;
            st_d = RBM_READ;
          end
        end
      end
      RBM_READ, RBM_WAIT:
      begin
        if (i_cpu_clk_en)
        begin
          if (cnt_q == 4'h1)
          begin
            case (cmd_q.op)
              RBM_OP_ROR: {a_d, psw_d[`RBM_CY_BIT]} = {a_q[0], a_q[7:1], a_q[0]};
              RBM_OP_ROL: {psw_d[`RBM_CY_BIT], a_d} = {a_q[7], a_q[6:0], a_q[7]};
              RBM_OP_ROTATE_RIGHT_THROUGH_CARRY: {a_d, psw_d[`RBM_CY_BIT]} = {psw_q[`RBM_CY_BIT], a_q};
              RBM_OP_ROTATE_LEFT_THROUGH_CARRY: {psw_d[`RBM_CY_BIT], a_d} = {a_q, psw_q[`RBM_CY_BIT]};
              RBM_OP_ROTATE_LEFT_WORD_THROUGH_CARRY:
              begin
                psw_d[`RBM_CY_BIT] = w[`RBM_WORD_MSB];
                if (cmd_q.word_sel) bc_d = {w[14:0], psw_q[`RBM_CY_BIT]};
                else ax_d = {w[14:0], psw_q[`RBM_CY_BIT]};
              end
              RBM_OP_MOV_TO_CY: psw_d[`RBM_CY_BIT] = src;
              RBM_OP_AND: psw_d[`RBM_CY_BIT] = psw_q[`RBM_CY_BIT] & src;
              RBM_OP_OR: psw_d[`RBM_CY_BIT] = psw_q[`RBM_CY_BIT] | src;
              RBM_OP_XOR: psw_d[`RBM_CY_BIT] = psw_q[`RBM_CY_BIT] ^ src;
              RBM_OP_MOV_FROM_CY, RBM_OP_SET, RBM_OP_CLR:
              begin
                mem_d.wdata = i_mem_rdata;
                if (cmd_q.am == RBM_AM_ACC) mem_d.wdata = a_q;
                if (cmd_q.am == RBM_AM_PSW) mem_d.wdata = psw_q;
                mem_d.wdata[cmd_q.bit_idx] = (cmd_q.op == RBM_OP_SET) ? 1'b1 :
                  (cmd_q.op == RBM_OP_CLR) ? 1'b0 : psw_q[`RBM_CY_BIT];
                if (cmd_q.am == RBM_AM_ACC) a_d = mem_d.wdata;
                else if (cmd_q.am == RBM_AM_PSW) psw_d = mem_d.wdata;
                else mem_d.wr = 1'b1;
                if (cmd_q.am != RBM_AM_ACC && cmd_q.am != RBM_AM_PSW)
                  mem_d.wdata = mem_d.wdata;
                else
                  mem_d.wdata = 8'h00;
              end
              RBM_OP_SET_CY: psw_d[`RBM_CY_BIT] = 1'b1;
              RBM_OP_CLR_CY: psw_d[`RBM_CY_BIT] = 1'b0;
              RBM_OP_NOT_CY: psw_d[`RBM_CY_BIT] = ~psw_q[`RBM_CY_BIT];
              default: psw_d = psw_q;
            endcase
          end
          if (cnt_q == clk_q)
          begin
            busy_d = 1'b0;
            done_d = 1'b1;
            st_d = RBM_IDLE;
          end
          cnt_d = cnt_q + 4'h1;
          if (st_q == RBM_READ) st_d = (cnt_q == clk_q) ? RBM_IDLE : RBM_WAIT;
        end
      end
      default: st_d = RBM_IDLE;
    endcase
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
    begin
      st_q <= RBM_IDLE;
      cmd_q <= '0;
      cnt_q <= 4'h0;
      clk_q <= 4'h0;
      len_q <= 3'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      a_q <= 8'h00;
      ax_q <= 16'h0000;
      bc_q <= 16'h0000;
      psw_q <= `RBM_PSW_RESET;
      mem_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      cnt_q <= cnt_d;
      clk_q <= clk_d;
      len_q <= len_d;
      busy_q <= busy_d;
      done_q <= done_d;
      a_q <= a_d;
      ax_q <= ax_d;
      bc_q <= bc_d;
      psw_q <= psw_d;
      mem_q <= mem_d;
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_len = len_q;
  assign o_clocks = clk_q;
  assign o_mem = mem_q;
  assign o_acc = a_q;
  assign o_word_ax = ax_q;
  assign o_word_bc = bc_q;
  assign o_psw = psw_q;
endmodule : rbm_exec
`default_nettype wire

// [rbm_exec_checker.sv]
// Timing and result assertions for the rotate and bit-operation unit.
// Assumes a bind onto rbm_exec; the enable is high around the ops checked.
`timescale 1ns/100ps
`default_nettype none
module rbm_exec_checker
  import rbm_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic i_start,
  input wire rbm_pkg::rbm_cmd_t i_cmd,
  input wire logic [7:0] i_mem_rdata,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [2:0] o_len,
  input wire logic [3:0] o_clocks,
  input wire rbm_pkg::rbm_mem_t o_mem,
  input wire logic [7:0] o_psw
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  logic tk;
  logic cy_q;
  logic [7:0] msk_q;
  assign tk = i_start && !o_busy && !i_cmd.ram_fetch;
  // Captured at the take edge, so the old carry is what gets inverted
  always_ff @(posedge I_SYS_CLK)
  begin
    if (tk)
    begin
      msk_q <= 8'h01 << i_cmd.bit_idx;
      cy_q <= o_psw[0];
    end
  end
  sequence s_rmw(logic [7:0] w);
    o_mem.rd ##1 (o_mem.wr && o_mem.wdata == w) ##1 o_done;
  endsequence
  a_set_rmw: assert property (tk && i_cmd.op == RBM_OP_SET &&
    i_cmd.am == RBM_AM_SADDR |=> s_rmw(i_mem_rdata | msk_q)) else $error("set write");
  a_clr_rmw: assert property (tk && i_cmd.op == RBM_OP_CLR &&
    i_cmd.am == RBM_AM_SADDR |=> s_rmw(i_mem_rdata & ~msk_q)) else $error("clear write");
  a_cy_set: assert property (tk && i_cmd.op == RBM_OP_SET_CY |-> ##2
    (o_done && o_psw[0] && o_clocks == 4'h1 && o_len == 3'h2)) else $error("carry set");
  a_cy_invert: assert property (tk && i_cmd.op == RBM_OP_NOT_CY |->
    ##2 (o_done && o_psw[0] == !cy_q)) else $error("carry invert");
  a_psw_write: assert property (tk && i_cmd.op == RBM_OP_MOV_FROM_CY &&
    i_cmd.am == RBM_AM_PSW |-> ##2 (o_clocks == 4'h4 && o_len == 3'h3) ##3 o_done)
    else $error("status write");
  a_code_read: assert property (tk && i_cmd.op == RBM_OP_MOV_TO_CY && i_cmd.code_area
    && !i_cmd.bank_q |-> ##5 (o_done && o_clocks == 4'h4)) else $error("code read");
  a_ram_fetch: assert property (i_start && !o_busy && i_cmd.ram_fetch &&
    i_cmd.op == RBM_OP_SET_CY |-> ##2 o_clocks == 4'h5) else $error("ram fetch");
  a_word_rot: assert property (tk && i_cmd.op == RBM_OP_ROTATE_LEFT_WORD_THROUGH_CARRY |->
    ##2 (o_len == 3'h2 && o_clocks == 4'h1)) else $error("word rotate");
endmodule : rbm_exec_checker
bind rbm_exec rbm_exec_checker u_chk (.I_SYS_CLK, .I_RST_N, .i_start, .i_cmd,
  .i_mem_rdata, .o_busy, .o_done, .o_len, .o_clocks, .o_mem, .o_psw);
`default_nettype wire

// [rbm_mem_model.sv]
// One byte of data memory on the far side of the unit.
// Assumes one read and at most one write per operation.
`timescale 1ns/100ps
`default_nettype none
module rbm_mem_model
  import rbm_pkg::*;
#(parameter logic [7:0] INIT = 8'hA5)
(
  input wire logic i_clk,
  input wire rbm_pkg::rbm_mem_t i_mem,
  input wire logic i_done,
  output logic [7:0] o_rdata,
  output logic [7:0] o_byte
);
  logic act_q = 1'b0;
  initial o_byte = INIT;
  always @(posedge i_clk)
  begin
    if (i_mem.wr)
      o_byte <= i_mem.wdata;
    act_q <= i_mem.rd ? 1'b1 : (i_done ? 1'b0 : act_q);
  end
  // The unit samples the byte while its read strobe stands, so the data answers at once
  // and holds until done; outside a read the bus shows the inverse, so stale data cannot pass
  assign o_rdata = (act_q || i_mem.rd) ? o_byte : ~o_byte;
endmodule : rbm_mem_model
`default_nettype wire

// [rotate_bit_manip_exec_bench.sv]
// Self-checking bench for the rotate and bit-operation unit.
// Assumes the memory model and checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module rotate_bit_manip_exec_bench;
  import rbm_pkg::*;
  logic I_SYS_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic en = 1'b1;
  logic thr = 1'b0;
  logic st = 1'b0;
  rbm_cmd_t cmd = '0;
  logic bsy, dn;
  logic [2:0] len;
  logic [3:0] clks;
  logic [7:0] rd, acc, program_status_word, mb;
  logic [15:0] ax, bc;
  rbm_mem_t mem;
  int num_errors = 0;
  int n_tests = 0;
  always #5 I_SYS_CLK = ~I_SYS_CLK;
  // Half-rate CPU clock while throttling
  always @(posedge I_SYS_CLK) en <= thr ? ~en : 1'b1;
  rbm_exec DUT (.I_SYS_CLK, .I_RST_N, .i_cpu_clk_en(en), .i_start(st), .i_cmd(cmd),
    .i_mem_rdata(rd), .o_busy(bsy), .o_done(dn), .o_len(len), .o_clocks(clks),
    .o_mem(mem), .o_acc(acc), .o_word_ax(ax), .o_word_bc(bc), .o_psw(program_status_word));
  rbm_mem_model u_mem (.i_clk(I_SYS_CLK), .i_mem(mem), .i_done(dn), .o_rdata(rd), .o_byte(mb));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // f holds bank, word select, code area and RAM fetch
  task automatic go(input rbm_op_t op, input rbm_am_t am, input logic [2:0] b,
    input logic [3:0] f);
    int i;
    @(posedge I_SYS_CLK) #1;
    st = 1'b1;
    cmd = '{op, am, f[3], f[2], b, f[1], f[0]};
    @(posedge I_SYS_CLK) #1;
    st = 1'b0;
    chk(bsy, 1'b1);
    for (i = 0; i < 40 && dn !== 1'b1; i++)
      @(posedge I_SYS_CLK) #1;
    if (dn !== 1'b1)
    begin
      num_errors++;
      finish_test();
    end
  endtask : go
  task automatic t_carry();
    go(RBM_OP_SET_CY, RBM_AM_NONE, 3'h0, 4'h0);
    chk({len, clks, program_status_word[0]}, {3'h2, 4'h1, 1'b1});
    go(RBM_OP_NOT_CY, RBM_AM_NONE, 3'h0, 4'h0);
    chk(program_status_word[0], 1'b0);
    go(RBM_OP_CLR_CY, RBM_AM_NONE, 3'h0, 4'h0);
    chk(program_status_word[0], 1'b0);
    go(RBM_OP_SET_CY, RBM_AM_NONE, 3'h0, 4'h1);
    chk(clks, 4'h5);
    $display("t_carry end");
  endtask : t_carry
  task automatic t_rot();
    go(RBM_OP_SET, RBM_AM_ACC, 3'h0, 4'h0);
    go(RBM_OP_SET, RBM_AM_ACC, 3'h7, 4'h0);
    chk({clks, acc}, {4'h1, 8'h81});
    go(RBM_OP_ROR, RBM_AM_ACC, 3'h0, 4'h0);
    chk({program_status_word[0], acc}, {1'b1, 8'hC0});
    go(RBM_OP_ROL, RBM_AM_ACC, 3'h0, 4'h0);
    chk({program_status_word[0], acc}, {1'b1, 8'h81});
    go(RBM_OP_ROTATE_RIGHT_THROUGH_CARRY, RBM_AM_ACC, 3'h0, 4'h0);
    chk({program_status_word[0], acc}, {1'b1, 8'hC0});
    go(RBM_OP_ROTATE_LEFT_THROUGH_CARRY, RBM_AM_ACC, 3'h0, 4'h0);
    chk({program_status_word[0], acc}, {1'b1, 8'h81});
    go(RBM_OP_CLR, RBM_AM_ACC, 3'h7, 4'h0);
    go(RBM_OP_MOV_FROM_CY, RBM_AM_ACC, 3'h1, 4'h0);
    chk({clks, acc}, {4'h1, 8'h03});
    $display("t_rot end");
  endtask : t_rot
  task automatic t_word();
    go(RBM_OP_ROTATE_LEFT_WORD_THROUGH_CARRY, RBM_AM_NONE, 3'h0, 4'h0);
    chk({program_status_word[0], ax}, {1'b0, 16'h0001});
    go(RBM_OP_SET_CY, RBM_AM_NONE, 3'h0, 4'h0);
    thr = 1'b1;
    go(RBM_OP_ROTATE_LEFT_WORD_THROUGH_CARRY, RBM_AM_NONE, 3'h0, 4'h4);
    thr = 1'b0;
    chk({program_status_word[0], clks, bc}, {1'b0, 4'h1, 16'h0001});
    $display("t_word end");
  endtask : t_word
  task automatic t_mem();
    go(RBM_OP_SET, RBM_AM_SADDR, 3'h3, 4'h0);
    chk({clks, mb}, {4'h2, 8'hAD});
    go(RBM_OP_CLR, RBM_AM_SADDR, 3'h0, 4'h0);
    chk(mb, 8'hAC);
    go(RBM_OP_MOV_TO_CY, RBM_AM_HL, 3'h2, 4'h2);
    chk({clks, program_status_word[0]}, {4'h4, 1'b1});
    go(RBM_OP_AND, RBM_AM_SADDR, 3'h4, 4'h0);
    chk(program_status_word[0], 1'b0);
    go(RBM_OP_OR, RBM_AM_HL, 3'h3, 4'h8);
    chk({clks, program_status_word[0]}, {4'h2, 1'b1});
    go(RBM_OP_XOR, RBM_AM_SADDR, 3'h5, 4'h0);
    chk(program_status_word[0], 1'b0);
    go(RBM_OP_MOV_FROM_CY, RBM_AM_SFR, 3'h7, 4'h0);
    chk({clks, mb}, {4'h2, 8'h2C});
    go(RBM_OP_MOV_FROM_CY, RBM_AM_PSW, 3'h1, 4'h0);
    chk({len, clks}, {3'h3, 4'h4});
    go(RBM_OP_SET, RBM_AM_ABS, 3'h0, 4'h8);
    chk({len, clks, mb}, {3'h5, 4'h3, 8'h2D});
    go(RBM_OP_SET, RBM_AM_PSW, 3'h2, 4'h0);
    chk(clks, 4'h4);
    $display("t_mem end");
  endtask : t_mem
  initial
  begin
    repeat (8) @(posedge I_SYS_CLK);
    #1;
    chk({acc, program_status_word}, 16'h0000);
    I_RST_N = 1'b1;
    t_carry();
    t_rot();
    t_word();
    t_mem();
    finish_test();
  end
endmodule : rotate_bit_manip_exec_bench
`default_nettype wire
